// file: src/cmcr_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the
  converter mode configuration register bank.
  Assumes a 25 MHz register clock and a 32-bit AXI4-Lite slave port.
*/
`ifndef CMCR_CONSTS_SVH
`define CMCR_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices and byte addresses
`define CMCR_IDX_CHOP_CONV      8'h03
`define CMCR_IDX_PIN_CON_DIR    8'h04
`define CMCR_IDX_PWR_PIN_DAT    8'h05
`define CMCR_IDX_REF_SEL        8'h06
`define CMCR_IDX_BLOCK_STATUS   8'h10
`define CMCR_ADDR(idx)          ((idx) << 2)

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define CMCR_RST_CHOP_CONV      8'h01
`define CMCR_RST_PIN_CON_DIR    8'h00
`define CMCR_RST_PWR_PIN_DAT    8'h00
`define CMCR_RST_REF_SEL        8'h05

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CMCR_CHOP_HI            6
`define CMCR_CHOP_LO            5
`define CMCR_CONV_BIT           4
`define CMCR_CON_HI             7
`define CMCR_CON_LO             4
`define CMCR_SOFT_POWER_DOWN_BIT           7
`define CMCR_STAT_BIT           6
`define CMCR_CHK_BIT            5
`define CMCR_ARST_BIT           4
`define CMCR_REF_MASK           8'h1f
`define CMCR_CHOP_MASK          8'h7f
`define CMCR_DLY_MAX_CODE       4'hd

////////////////////////////////////////////////////////////////////////////////
// Start delays in ns, counts at the 25 MHz register clock
`define CMCR_CLK_MHZ            25
`define CMCR_NS2CYC(ns)         ((((ns) * `CMCR_CLK_MHZ) + 999) / 1000)
`define CMCR_DLY_00_NS          0
`define CMCR_DLY_01_NS          50000
`define CMCR_DLY_02_NS          59000
`define CMCR_DLY_03_NS          67000
`define CMCR_DLY_04_NS          85000
`define CMCR_DLY_05_NS          119000
`define CMCR_DLY_06_NS          189000
`define CMCR_DLY_07_NS          328000
`define CMCR_DLY_08_NS          605000
`define CMCR_DLY_09_NS          1160000
`define CMCR_DLY_10_NS          2270000
`define CMCR_DLY_11_NS          4490000
`define CMCR_DLY_12_NS          8930000
`define CMCR_DLY_13_NS          17800000

`endif

// file: src/cmcr_pkg.sv
/*
  Types of the converter mode configuration register bank.
  Assumes nothing beyond a SystemVerilog package scope.
*/
package cmcr_pkg;

  // Conversion sequencer states, Gray coded along idle-delay-convert
  typedef enum logic [1:0]
  {
    CMCR_IDLE    = 2'b00,
    CMCR_DELAY   = 2'b01,
    CMCR_CONVERT = 2'b11
  } cmcr_state_t;

  // Chop field codes
  typedef enum logic [1:0]
  {
    CMCR_CHOP_NORMAL = 2'b00,
    CMCR_CHOP_ON     = 2'b01,
    CMCR_AC_2WIRE    = 2'b10,
    CMCR_AC_4WIRE    = 2'b11
  } cmcr_chop_t;

  // Register select from the address decoder
  typedef enum logic [2:0]
  {
    CMCR_SEL_NONE = 3'h0,
    CMCR_SEL_CHOP = 3'h1,
    CMCR_SEL_PIN  = 3'h2,
    CMCR_SEL_PWR  = 3'h3,
    CMCR_SEL_REF  = 3'h4,
    CMCR_SEL_STAT = 3'h5
  } cmcr_sel_t;

endpackage

// file: src/cmcr_timer_if.sv
/*
  Carrier between the register bank and its start-delay timer.
  Assumes both ends run on the same clock.
*/
interface cmcr_timer_if #(
  parameter int unsigned CNT_W = 19
);
  logic             load;        // One-cycle request to start a delay
  logic [CNT_W-1:0] load_count;  // Delay length in clock cycles
  logic             busy;        // Delay running
  logic             done;        // One-cycle pulse at the delay end

  modport master (output load, output load_count, input busy, input done);
  modport slave  (input load, input load_count, output busy, output done);
endinterface

// file: src/cmcr_delay_timer.sv
/*
  Down-counter that times the conversion-start delay.
  Assumes a load count of one or more and a single clock domain.
*/
module cmcr_delay_timer #(
  parameter int unsigned CNT_W = 19
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  cmcr_timer_if.slave tmr
);

  logic [CNT_W-1:0] count_r;  // Cycles left
  logic             done_r;   // End pulse

  if (CNT_W < 2)
  begin : g_chk
    $error("cmcr_delay_timer: CNT_W too small");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Load, count down, stop at zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= '0;
    else if (tmr.load)
      count_r <= tmr.load_count;
    else if (count_r != '0)
      count_r <= count_r - 1'b1;
  end

  // Pulse when the last cycle runs out, N cycles after the load edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_r <= 1'b0;
    else
      done_r <= !tmr.load && (count_r == {{(CNT_W-1){1'b0}}, 1'b1});
  end

  assign tmr.busy = (count_r != '0);
  assign tmr.done = done_r;

endmodule

// file: src/cmcr_top.sv
/*
  Converter mode configuration register bank with its conversion-start
  sequencer, general-purpose pin control and check-error flag.
  Assumes an AXI4-Lite master on aclk, core strobes on aclk and pin
  inputs from outside the clock domain.
*/
`include "cmcr_consts.svh"

module cmcr_top #(
  parameter int unsigned ADDR_W        = 8,     // AXI byte address width
  parameter bit          LARGE_VARIANT = 1'b1,  // AC excitation available
  parameter int unsigned CNT_W         = 19,    // Delay counter width
  // Start-delay lengths in cycles for codes 0 to 13
  parameter int unsigned DELAY_CYC [14] = '{
    1,
    `CMCR_NS2CYC(`CMCR_DLY_01_NS), `CMCR_NS2CYC(`CMCR_DLY_02_NS),
    `CMCR_NS2CYC(`CMCR_DLY_03_NS), `CMCR_NS2CYC(`CMCR_DLY_04_NS),
    `CMCR_NS2CYC(`CMCR_DLY_05_NS), `CMCR_NS2CYC(`CMCR_DLY_06_NS),
    `CMCR_NS2CYC(`CMCR_DLY_07_NS), `CMCR_NS2CYC(`CMCR_DLY_08_NS),
    `CMCR_NS2CYC(`CMCR_DLY_09_NS), `CMCR_NS2CYC(`CMCR_DLY_10_NS),
    `CMCR_NS2CYC(`CMCR_DLY_11_NS), `CMCR_NS2CYC(`CMCR_DLY_12_NS),
    `CMCR_NS2CYC(`CMCR_DLY_13_NS)}
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              conv_start,
  input  wire logic              conv_done,
  input  wire logic              check_error_detect,
  output logic                   conv_delay_active,
  output logic                   conv_running,
  output logic                   chop_enable,
  output logic                   ac_excite_2wire,
  output logic                   ac_excite_4wire,
  output logic                   soft_power_down,
  output logic                   status_byte_enable,
  output logic                   check_code_enable,
  output logic                   serial_auto_reset_enable,
  output logic                   internal_ref_enable,
  output logic [1:0]             ref_pos_select,
  output logic [1:0]             ref_neg_select,
  output logic [3:0]             pin_analog_connect,
  input  wire logic [3:0]        pin_i,
  output logic [3:0]             pin_o,
  output logic [3:0]             pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (ADDR_W < 8)
  begin : g_chk_addr
    $error("cmcr_top: ADDR_W below 8");
  end
  for (genvar gi = 0; gi < 14; gi++)
  begin : g_chk_cyc
    if ((DELAY_CYC[gi] < 1) || (DELAY_CYC[gi] >= (64'd1 << CNT_W)))
    begin : g_bad
      $error("cmcr_top: delay count does not fit CNT_W");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte address to register select; unaligned or unknown gives none
  function automatic cmcr_pkg::cmcr_sel_t cmcr_decode(input logic [ADDR_W-1:0] addr);
    cmcr_pkg::cmcr_sel_t sel;
    sel = cmcr_pkg::CMCR_SEL_NONE;
    if (addr == ADDR_W'(`CMCR_ADDR(`CMCR_IDX_CHOP_CONV)))
      sel = cmcr_pkg::CMCR_SEL_CHOP;
    else if (addr == ADDR_W'(`CMCR_ADDR(`CMCR_IDX_PIN_CON_DIR)))
      sel = cmcr_pkg::CMCR_SEL_PIN;
    else if (addr == ADDR_W'(`CMCR_ADDR(`CMCR_IDX_PWR_PIN_DAT)))
      sel = cmcr_pkg::CMCR_SEL_PWR;
    else if (addr == ADDR_W'(`CMCR_ADDR(`CMCR_IDX_REF_SEL)))
      sel = cmcr_pkg::CMCR_SEL_REF;
    else if (addr == ADDR_W'(`CMCR_ADDR(`CMCR_IDX_BLOCK_STATUS)))
      sel = cmcr_pkg::CMCR_SEL_STAT;
    return sel;
  endfunction

  // Delay code to table index; reserved codes fall back to the longest
  function automatic logic [3:0] cmcr_delay_index(input logic [3:0] code);
    return (code > `CMCR_DLY_MAX_CODE) ? `CMCR_DLY_MAX_CODE : code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  chop_conv_r;       // Chop, conversion mode, delay code
  logic [7:0]  pin_con_dir_r;     // Pin connect and direction
  logic [7:0]  pwr_pin_dat_r;     // Power, interface and pin data
  logic [7:0]  ref_sel_r;         // Reference configuration
  logic        check_err_r;       // Sticky check-code error
  logic [3:0]  pin_meta_r;        // Pin synchroniser, first stage
  logic [3:0]  pin_sync_r;        // Pin synchroniser, second stage
  logic        aw_held_r;         // Write address captured
  logic        w_held_r;          // Write data captured
  logic [ADDR_W-1:0] aw_addr_r;   // Captured write address
  logic [7:0]  w_data_r;          // Captured low write byte
  logic        w_lane0_r;         // Low byte lane enabled
  logic        wr_fire;           // Register write this cycle
  cmcr_pkg::cmcr_sel_t wr_sel;    // Write target
  cmcr_pkg::cmcr_sel_t rd_sel;    // Read target
  logic [7:0]  rd_byte;           // Read data before the output flop
  cmcr_pkg::cmcr_state_t state_r; // Sequencer state
  cmcr_pkg::cmcr_state_t state_nxt;
  logic        start_ok;          // Start request outside power-down this cycle

  cmcr_timer_if #(.CNT_W(CNT_W)) tmr ();

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_sel  = cmcr_decode(aw_addr_r);

  // Address and data taken in either order, released after the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= 8'h00;
      w_lane0_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_held_r)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r     <= 1'b1;
        w_data_r     <= s_axi_wdata[7:0];
        w_lane0_r    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      else if (!w_held_r)
        s_axi_wready <= 1'b1;
      // Response once both halves are in; unmapped answers SLVERR
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == cmcr_pkg::CMCR_SEL_NONE) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chop_conv_r   <= `CMCR_RST_CHOP_CONV;
      pin_con_dir_r <= `CMCR_RST_PIN_CON_DIR;
      pwr_pin_dat_r <= `CMCR_RST_PWR_PIN_DAT;
      ref_sel_r     <= `CMCR_RST_REF_SEL;
    end
    else if (wr_fire && w_lane0_r)
    begin
      case (wr_sel)
        cmcr_pkg::CMCR_SEL_CHOP: chop_conv_r   <= w_data_r & `CMCR_CHOP_MASK;
        cmcr_pkg::CMCR_SEL_PIN:  pin_con_dir_r <= w_data_r;
        cmcr_pkg::CMCR_SEL_PWR:  pwr_pin_dat_r <= w_data_r;
        cmcr_pkg::CMCR_SEL_REF:  ref_sel_r     <= w_data_r & `CMCR_REF_MASK;
        default:                 ;
      endcase
    end
  end

  // Sticky error: detection wins over a write-one clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      check_err_r <= 1'b0;
    else if (check_error_detect && pwr_pin_dat_r[`CMCR_CHK_BIT])
      check_err_r <= 1'b1;
    else if (wr_fire && w_lane0_r && (wr_sel == cmcr_pkg::CMCR_SEL_STAT) && w_data_r[0])
      check_err_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign rd_sel = cmcr_decode(s_axi_araddr);

  // Read data mux
  always_comb
  begin
    case (rd_sel)
      cmcr_pkg::CMCR_SEL_CHOP: rd_byte = chop_conv_r;
      cmcr_pkg::CMCR_SEL_PIN:  rd_byte = pin_con_dir_r;
      cmcr_pkg::CMCR_SEL_PWR:  rd_byte = {pwr_pin_dat_r[7:4], pin_sync_r};
      cmcr_pkg::CMCR_SEL_REF:  rd_byte = ref_sel_r;
      cmcr_pkg::CMCR_SEL_STAT: rd_byte = {4'h0, tmr.busy, conv_running,
                                          conv_delay_active, check_err_r};
      default:                 rd_byte = 8'h00;
    endcase
  end

  // One read at a time, answer the cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= (rd_sel == cmcr_pkg::CMCR_SEL_NONE) ? 2'h2 : 2'h0;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid  <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion-start sequencer
  // power-down blocks starts
  assign start_ok = conv_start && !pwr_pin_dat_r[`CMCR_SOFT_POWER_DOWN_BIT];

  assign tmr.load       = (state_r == cmcr_pkg::CMCR_IDLE) && start_ok
                          || (state_r == cmcr_pkg::CMCR_CONVERT) && conv_done
                             && !chop_conv_r[`CMCR_CONV_BIT]
                             && !pwr_pin_dat_r[`CMCR_SOFT_POWER_DOWN_BIT];
  assign tmr.load_count = CNT_W'(DELAY_CYC[cmcr_delay_index(chop_conv_r[3:0])]);

  cmcr_delay_timer #(
    .CNT_W   (CNT_W)
  ) u_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr)
  );

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      cmcr_pkg::CMCR_IDLE:
        if (start_ok)
          state_nxt = cmcr_pkg::CMCR_DELAY;
      cmcr_pkg::CMCR_DELAY:
        if (tmr.done)
          state_nxt = cmcr_pkg::CMCR_CONVERT;
      cmcr_pkg::CMCR_CONVERT:
        if (conv_done)
        begin
          if (chop_conv_r[`CMCR_CONV_BIT])
            state_nxt = cmcr_pkg::CMCR_IDLE;
          else
            state_nxt = cmcr_pkg::CMCR_DELAY;
        end
      default:
        state_nxt = cmcr_pkg::CMCR_IDLE;
    endcase
    if (pwr_pin_dat_r[`CMCR_SOFT_POWER_DOWN_BIT])
      state_nxt = cmcr_pkg::CMCR_IDLE;
  end

  // State and its registered flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r           <= cmcr_pkg::CMCR_IDLE;
      conv_delay_active <= 1'b0;
      conv_running      <= 1'b0;
    end
    else
    begin
      state_r           <= state_nxt;
      conv_delay_active <= (state_nxt == cmcr_pkg::CMCR_DELAY);
      conv_running      <= (state_nxt == cmcr_pkg::CMCR_CONVERT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and interface outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chop_enable              <= 1'b0;
      ac_excite_2wire          <= 1'b0;
      ac_excite_4wire          <= 1'b0;
      soft_power_down          <= 1'b0;
      status_byte_enable       <= 1'b0;
      check_code_enable        <= 1'b0;
      serial_auto_reset_enable <= 1'b0;
      internal_ref_enable      <= 1'b0;
      ref_pos_select           <= 2'h1;
      ref_neg_select           <= 2'h1;
    end
    else
    begin
      chop_enable     <= (chop_conv_r[`CMCR_CHOP_HI:`CMCR_CHOP_LO] == cmcr_pkg::CMCR_CHOP_ON);
      ac_excite_2wire <= LARGE_VARIANT
                         && (chop_conv_r[`CMCR_CHOP_HI:`CMCR_CHOP_LO] == cmcr_pkg::CMCR_AC_2WIRE);
      ac_excite_4wire <= LARGE_VARIANT
                         && (chop_conv_r[`CMCR_CHOP_HI:`CMCR_CHOP_LO] == cmcr_pkg::CMCR_AC_4WIRE);
      soft_power_down          <= pwr_pin_dat_r[`CMCR_SOFT_POWER_DOWN_BIT];
      status_byte_enable       <= pwr_pin_dat_r[`CMCR_STAT_BIT];
      check_code_enable        <= pwr_pin_dat_r[`CMCR_CHK_BIT];
      serial_auto_reset_enable <= pwr_pin_dat_r[`CMCR_ARST_BIT];
      internal_ref_enable      <= ref_sel_r[4];
      ref_pos_select           <= ref_sel_r[3:2];
      ref_neg_select           <= ref_sel_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General-purpose pins
  // Two-stage synchroniser on the pin levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end
    else
    begin
      pin_meta_r <= pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Pin drive: only connected pins set as outputs are driven
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_analog_connect <= 4'h0;
      pin_o              <= 4'h0;
      pin_oe             <= 4'h0;
    end
    else
    begin
      pin_analog_connect <= pin_con_dir_r[`CMCR_CON_HI:`CMCR_CON_LO];
      pin_o              <= pwr_pin_dat_r[3:0];
      pin_oe             <= pin_con_dir_r[`CMCR_CON_HI:`CMCR_CON_LO] & ~pin_con_dir_r[3:0];
    end
  end

endmodule

// file: verification/cmcr_top_sva.sv
/*
  Port checker for the converter mode configuration register bank.
  Assumes a bind to cmcr_top and one clock with synchronous reset.
*/
module cmcr_top_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic        conv_delay_active,
  input wire logic        conv_running,
  input wire logic        chop_enable,
  input wire logic        ac_excite_2wire,
  input wire logic        ac_excite_4wire,
  input wire logic        soft_power_down,
  input wire logic [3:0]  pin_analog_connect,
  input wire logic [3:0]  pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain for every property
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Start accepted while idle and powered up
  sequence start_ok;
    conv_start && !conv_delay_active && !conv_running && !soft_power_down;
  endsequence
  // Done strobe seen while converting
  sequence conv_end;
    conv_running && conv_done;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  chop_mode_a: assert property ($onehot0({chop_enable, ac_excite_2wire, ac_excite_4wire}))
    else $error("several chop modes decoded at once");
  conv_end_a: assert property (conv_end |=> !conv_running)
    else $error("conversion still running after done");
  start_delay_a: assert property (start_ok ##1 !soft_power_down |-> conv_delay_active)
    else $error("start did not open the delay");
  run_after_delay_a: assert property ($rose(conv_running) |-> $past(conv_delay_active))
    else $error("conversion began without a delay");
  pin_drive_a: assert property ((pin_oe & ~pin_analog_connect) == 4'h0)
    else $error("pin driven while not connected");
  power_idle_a: assert property (soft_power_down |-> !conv_running && !conv_delay_active)
    else $error("sequencer active in power-down");
  wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

// file: verification/converter_mode_config_regs_test.sv
/*
  Self-checking bench of the register bank, model in assoc arrays.
  Assumes cmcr_top and cmcr_top_sva are compiled before it.
*/
module converter_mode_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus and core stimulus
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, conv_start, conv_done, check_error_detect, cerr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, d;
  logic [3:0]  s_axi_wstrb, pin_i;
  // Design outputs
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        conv_delay_active, conv_running, chop_enable, ac_excite_2wire, ac_excite_4wire;
  logic        soft_power_down, status_byte_enable, check_code_enable, serial_auto_reset_enable;
  logic        internal_ref_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ref_pos_select, ref_neg_select;
  logic [31:0] s_axi_rdata;
  logic [3:0]  pin_analog_connect, pin_o, pin_oe;
  // Model registers, stored-bit masks, probed places
  logic [7:0]  mdl [int];
  logic [7:0]  mskt [int] = '{'h0c:'h7f, 'h10:'hff, 'h14:'hff, 'h18:'h1f};
  logic [7:0]  adr [8] = '{'h0c, 'h10, 'h14, 'h18, 'h40, 'h00, 'h1c, 'h44};
  int          mismatches, n_tests;
  // Shortened start delays in cycles for codes 0 to 13
  localparam int unsigned DLY [14] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16};

  cmcr_top #(.DELAY_CYC(DLY)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .conv_done,
    .check_error_detect, .conv_delay_active, .conv_running, .chop_enable, .ac_excite_2wire,
    .ac_excite_4wire, .soft_power_down, .status_byte_enable, .check_code_enable,
    .serial_auto_reset_enable, .internal_ref_enable, .ref_pos_select, .ref_neg_select,
    .pin_analog_connect, .pin_i, .pin_o, .pin_oe);

  // 25 MHz clock
  always #20 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Bus write, then model update once the strobe is settled
  task automatic wm(input logic [7:0] a, input logic [31:0] dd);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, (mdl.exists(a) || a == 8'h40) ? 2'b00 : 2'b10);
    if (mdl.exists(a) && s_axi_wstrb[0]) mdl[a] = dd[7:0] & mskt[a];
    if (a == 8'h40 && s_axi_wstrb[0] && dd[0]) cerr = 1'b0;
  endtask

  // Bus read against the model; pin bits come from the inputs
  task automatic rm(input logic [7:0] a);
    logic [33:0] e;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    e = {2'b10, 32'h0};
    if (mdl.exists(a)) e = {26'h0, mdl[a]};
    if (a == 8'h14) e[3:0] = pin_i;
    if (a == 8'h40) e = {33'h0, cerr};
    chk("read", {s_axi_rresp, s_axi_rdata}, e);
  endtask

  // Field outputs against the model
  task automatic outs();
    logic [7:0] c, p, q, r;
    c = mdl['h0c];
    p = mdl['h10];
    q = mdl['h14];
    r = mdl['h18];
    repeat (3) @(posedge aclk);
    chk("fields", {chop_enable, ac_excite_2wire, ac_excite_4wire, soft_power_down,
      status_byte_enable, check_code_enable, serial_auto_reset_enable, internal_ref_enable,
      ref_pos_select, ref_neg_select, pin_analog_connect, pin_o, pin_oe},
      {c[6:5] == 2'h1, c[6:5] == 2'h2, c[6:5] == 2'h3, q[7:4], r[4:0], p[7:4], q[3:0],
      p[7:4] & ~p[3:0]});
  endtask

  // One-cycle strobe: 0 start, 1 done, 2 check error
  task automatic pulse(input int w);
    @(posedge aclk);
    {check_error_detect, conv_done, conv_start} <= 3'(1 << w);
    @(posedge aclk);
    {check_error_detect, conv_done, conv_start} <= 3'h0;
    if (w == 2) cerr = cerr | mdl['h14][5];
  endtask

  // Start, count delay cycles, end with done
  task automatic conv(input int c, input bit one);
    int n;
    n = 0;
    wm(8'h0c, 32'(one * 16 + c));
    pulse(0);
    while (conv_running !== 1'b1 && n < 99)
    begin
      @(posedge aclk);
      n += conv_delay_active;
    end
    // Delay flag stands one cycle past the count while the sequencer moves on
    chk("delay", n, DLY[c] + 1);
    pulse(1);
    @(posedge aclk);
    chk("after", {conv_running, conv_delay_active}, {1'b0, !one});
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, conv_start, conv_done, check_error_detect, cerr, pin_i} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    mdl = '{'h0c:8'h01, 'h10:8'h00, 'h14:8'h00, 'h18:8'h05};
    void'($urandom(24829));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (adr[i]) rm(adr[i]);
    for (int k = 0; k < 8; k++)
    begin
      foreach (adr[i])
      begin
        d = $urandom;
        d[6:5] = k[1:0];
        if (adr[i] == 8'h0c) d[7:0] = {1'b0, d[6:4], (d[3:0] > 4'hd) ? 4'h0 : d[3:0]};
        s_axi_wstrb <= (k < 4) ? 4'hf : 4'($urandom);
        pin_i <= 4'($urandom);
        wm(adr[i], d);
        rm(adr[i]);
      end
      outs();
    end
    s_axi_wstrb <= 4'hf;
    wm(8'h14, 32'h00);
    pulse(2);
    rm(8'h40);
    wm(8'h14, 32'h20);
    pulse(2);
    rm(8'h40);
    wm(8'h40, 32'h00);
    rm(8'h40);
    wm(8'h40, 32'h01);
    rm(8'h40);
    // No rate register here, so the zero-delay code is legal; reserved codes never written
    for (int c = 0; c < 14; c++) conv(c, 1'b1);
    conv(2, 1'b0);
    wm(8'h14, 32'h80);
    pulse(0);
    repeat (2) @(posedge aclk);
    chk("halt", {conv_running, conv_delay_active}, 2'b00);
    end_of_test();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end
endmodule

bind cmcr_top cmcr_top_sva u_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .conv_start, .conv_done, .conv_delay_active,
  .conv_running, .chop_enable, .ac_excite_2wire, .ac_excite_4wire, .soft_power_down,
  .pin_analog_connect, .pin_oe);
